// ==== common/fpu_exc_pkg.sv ====
// Shared constants and types for the numeric coprocessor exception unit.
// Assumes a single 10 MHz clock domain and a plain register port.
package fpu_exc_pkg;

   // Register port geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_EVT_STAT = 8'h08;
   localparam logic [7:0] OFS_EVT_CLR = 8'h0C;
   localparam logic [7:0] OFS_EVT_EN = 8'h10;

   // Exception flag and mask positions, lowest index wins precedence
   localparam int EXC_W = 6;
   localparam int EXC_IE = 0;
   localparam int EXC_DE = 1;
   localparam int EXC_ZE = 2;
   localparam int EXC_OE = 3;
   localparam int EXC_UE = 4;
   localparam int EXC_PE = 5;
   localparam logic [5:0] BEFORE_SET = 6'h07;
   localparam logic [5:0] CTRL_MASK_RST = 6'h3F;

   // Status word field positions
   localparam int SW_SF = 6;
   localparam int SW_ES = 7;
   localparam int SW_CC_ZERO = 8;
   localparam int SW_CC_ONE = 9;
   localparam int SW_CC_TWO = 10;
   localparam int SW_TOP = 11;
   localparam int SW_CC_THREE = 14;
   localparam int SW_B = 15;
   localparam logic [3:0] CC_RST = 4'h0;

   // Event bits of the interrupt registers
   localparam int EVT_W = 3;
   localparam int EVT_EXC = 0;
   localparam int EVT_ERR = 1;
   localparam int EVT_CC = 2;
   localparam logic [2:0] EVT_RST = 3'h0;

   // Instruction classes seen by this unit
   typedef enum logic [2:0] {
      OP_ARITH, OP_STORE, OP_STORE_POP, OP_COMPARE,
      OP_COMPARE_POP, OP_EXAMINE, OP_STATUS_TO_ACC
   } op_kind_t;

   // Compare ordering from the datapath
   typedef enum logic [1:0] {ORD_GT, ORD_LT, ORD_EQ, ORD_UNORD} order_t;

   // Operand class for the examine instruction
   typedef enum logic [2:0] {
      CLS_UNSUPP, CLS_NAN, CLS_NORMAL, CLS_INF,
      CLS_ZERO, CLS_EMPTY, CLS_DENORM
   } class_t;

   // Issue request with operand checks done before any state change
   typedef struct packed {
      op_kind_t kind;
      logic inv;
      logic zdiv;
      logic denorm;
   } op_req_t;

   // Computed result report
   typedef struct packed {
      logic ovf;
      logic unf;
      logic prec;
      order_t order;
      class_t vclass;
      logic sign;
   } res_t;

   // Commit decision towards stack and memory
   typedef struct packed {
      logic valid;
      logic wr_stack;
      logic wr_mem;
      logic pop;
      logic use_default;
      logic aborted;
   } commit_t;

endpackage

// ==== rtl/exc_prio.sv ====
// Precedence picker for simultaneous numeric exceptions.
// Purely combinational; used by the commit unit on one clock.
`timescale 1ns/1ns
module exc_prio
   import fpu_exc_pkg::*;
(
   input wire logic [EXC_W-1:0] raw, // Detected exceptions
   input wire logic [EXC_W-1:0] mask, // Mask bits, 1 = masked
   output logic [EXC_W-1:0] pick, // One-hot highest exception
   output logic unmasked // Picked one is not masked
);

   logic [EXC_W:0] seen; // Any higher exception already present

   assign seen[0] = 1'b0;

   // Lowest index has the highest precedence
   genvar i;
   generate
      for (i = 0; i < EXC_W; i++)
      begin : g_prio
         assign pick[i] = raw[i] & ~seen[i];
         assign seen[i+1] = seen[i] | raw[i];
      end
   endgenerate

   // The picked exception alone decides masked or unmasked
   assign unmasked = |(pick & ~mask);

endmodule

// ==== rtl/cond_code_enc.sv ====
// Condition code encoder for compare and examine results.
// Output is {bit3, bit2, bit1, bit0}; combinational.
`timescale 1ns/1ns
module cond_code_enc
   import fpu_exc_pkg::*;
(
   input wire logic is_examine, // 1 = examine, 0 = compare
   input wire order_t order, // Compare ordering
   input wire class_t vclass, // Examined value class
   input wire logic sign, // Examined value sign
   output logic [3:0] cc // Condition bits 3..0
);

   // Decode ordering or class into the four bits
   always_comb
   begin
      cc = 4'h0;
      if (is_examine)
      begin
         // Bit 1 carries the sign; empty is only 10x1 with bit2 clear
         case (vclass)
            CLS_UNSUPP: cc = {3'h0, 1'b0};
            CLS_NAN: cc = 4'h1;
            CLS_NORMAL: cc = 4'h4;
            CLS_INF: cc = 4'h5;
            CLS_ZERO: cc = 4'h8;
            CLS_EMPTY: cc = 4'h9;
            CLS_DENORM: cc = 4'hC;
            default: cc = 4'h0;
         endcase
         cc[1] = sign;
      end
      else
      begin
         case (order)
            ORD_GT: cc = 4'h0;
            ORD_LT: cc = 4'h1;
            ORD_EQ: cc = 4'h8;
            ORD_UNORD: cc = 4'hD;
            default: cc = 4'h0;
         endcase
      end
   end

endmodule

// ==== rtl/fpu_exc_commit.sv ====
// Exception recognition, commit control and condition codes for the
// numeric coprocessor. Assumes one clock, a host that samples the
// error pin at its next escape or wait instruction, and a datapath
// that reports operand checks at issue and result flags later.
//
// Summary of operation
// - Operand exceptions checked before any state change
// - Result exceptions raised only after result computed
// - Unmasked operand exception commits nothing
// - Result exceptions still allow normal commit
// - Store with unmasked over/underflow writes nothing
// - Bits 3,2,0 sit in status high byte
// - Compare orderings encoded in bits 3,2,0
// - Status word stored straight to accumulator
// - Examine sets four bits, empty codes limited
// - Unmasked exception drives active-low error pin
// - Masked exception corrected, no host signal; irq still rises for it if EVT_EXC is enabled
// - Only highest-precedence exception reported
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ns
module fpu_exc_commit
   import fpu_exc_pkg::*;
(
   input wire logic clk_sys, // System clock, 10 MHz
   input wire logic rstn, // Asynchronous reset, active low
   input wire logic [ADDR_W-1:0] reg_addr, // Register address
   input wire logic [DATA_W-1:0] reg_wdata, // Register write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   output logic [DATA_W-1:0] reg_rdata, // Read data, next cycle
   input wire logic op_valid, // Instruction issue strobe
   input wire op_req_t op_req, // Instruction and operand checks
   output logic op_ready, // Unit can take an instruction
   input wire logic res_valid, // Result computed strobe
   input wire res_t res, // Result flags and codes
   input wire logic [2:0] stack_top, // Current stack top pointer
   output commit_t commit, // Commit decision, one-cycle valid
   output logic acc_valid, // Status word to accumulator strobe
   output logic [15:0] acc_data, // Status word for accumulator
   output logic error_n, // Error pin to host, active low
   output logic irq // Level interrupt, active high
);

   ////////////////////////////////////////////////////////////////////
   // Declarations
   ////////////////////////////////////////////////////////////////////

   typedef enum logic [1:0] {S_IDLE, S_WAIT_RES} state_t;

   state_t state_r; // Sequencer state
   state_t state_nxt; // Next sequencer state
   logic [EXC_W-1:0] mask_r; // Exception masks
   logic [EXC_W-1:0] flags_r; // Sticky exception flags
   logic [3:0] cc_r; // Condition bits 3..0
   op_kind_t kind_r; // Kind of instruction in flight
   logic dflt_r; // Masked operand fault corrected
   logic [EVT_W-1:0] evt_r; // Sticky event status
   logic [EVT_W-1:0] evt_en_r; // Event enables
   logic [15:0] sw; // Assembled status word
   logic es; // Exception summary
   logic [EXC_W-1:0] before_raw; // Operand-check exceptions
   logic [EXC_W-1:0] after_raw; // Result exceptions
   logic [EXC_W-1:0] before_pick; // Chosen operand exception
   logic [EXC_W-1:0] after_pick; // Chosen result exception
   logic before_unm; // Chosen operand exception unmasked
   logic after_unm; // Chosen result exception unmasked
   logic [3:0] cc_new; // Encoded condition bits
   logic issue; // Instruction taken this cycle
   logic finish; // Result taken this cycle
   logic is_store; // In-flight instruction stores
   logic set_flags; // Flags set this cycle
   logic [EXC_W-1:0] flag_set; // Which flags are set
   logic cc_upd; // Condition bits updated
   logic err_evt; // Unmasked exception raised
   logic wr_ctrl; // Control register write
   logic wr_status; // Status flag clear write
   logic wr_evt_clr; // Event clear write
   logic wr_evt_en; // Event enable write

   ////////////////////////////////////////////////////////////////////
   // Exception detection
   ////////////////////////////////////////////////////////////////////

   // Operand checks arrive with the issue, before any update
   assign before_raw = {3'h0, op_req.zdiv, op_req.denorm,
                        op_req.inv};

   // Result flags are only looked at with the computed result
   assign after_raw = {res.prec, res.unf, res.ovf, 3'h0};

   // Precedence for operand-time exceptions
   exc_prio u_prio_before (
      .raw(before_raw),
      .mask(mask_r),
      .pick(before_pick),
      .unmasked(before_unm)
   );

   // Precedence for result-time exceptions
   exc_prio u_prio_after (
      .raw(after_raw),
      .mask(mask_r),
      .pick(after_pick),
      .unmasked(after_unm)
   );

   // Condition code encoding from the result report
   cond_code_enc u_cc (
      .is_examine(kind_r == OP_EXAMINE),
      .order(res.order),
      .vclass(res.vclass),
      .sign(res.sign),
      .cc(cc_new)
   );

   ////////////////////////////////////////////////////////////////////
   // Sequencer
   ////////////////////////////////////////////////////////////////////

   assign op_ready = (state_r == S_IDLE);
   assign issue = op_valid & op_ready;
   assign finish = res_valid & (state_r == S_WAIT_RES);
   assign is_store = (kind_r == OP_STORE) | (kind_r == OP_STORE_POP);

   // Next state: unmasked operand faults and status stores end at once
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         S_IDLE:
         begin
            if (issue && op_req.kind != OP_STATUS_TO_ACC &&
                !before_unm)
               state_nxt = S_WAIT_RES;
         end
         S_WAIT_RES:
         begin
            if (res_valid)
               state_nxt = S_IDLE;
         end
         default: state_nxt = S_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         state_r <= S_IDLE;
      else
         state_r <= state_nxt;
   end

   // Remember the kind and any masked operand correction
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         kind_r <= OP_ARITH;
         dflt_r <= 1'b0;
      end
      else if (issue)
      begin
         kind_r <= op_req.kind;
         dflt_r <= |before_pick;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Commit decision
   ////////////////////////////////////////////////////////////////////

   // Issue-time abort or result-time commit, one-cycle valid
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         commit <= '0;
      else
      begin
         commit <= '0;
         if (issue && op_req.kind != OP_STATUS_TO_ACC && before_unm)
         begin
            // Nothing is written and nothing popped
            commit.valid <= 1'b1;
            commit.aborted <= 1'b1;
         end
         else if (finish)
         begin
            commit.valid <= 1'b1;
            commit.use_default <= dflt_r;
            if (is_store && !dflt_r && after_unm &&
                (after_pick[EXC_OE] || after_pick[EXC_UE]))
               commit.aborted <= 1'b1;
            else
            begin
               // Result-time exceptions do not block the update
               commit.wr_stack <= (kind_r == OP_ARITH);
               commit.wr_mem <= is_store;
               commit.pop <= (kind_r == OP_STORE_POP) ||
                             (kind_r == OP_COMPARE_POP);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Exception flags and error pin
   ////////////////////////////////////////////////////////////////////

   // An operand fault outranks any later result exception
   always_comb
   begin
      flag_set = '0;
      err_evt = 1'b0;
      if (issue && op_req.kind != OP_STATUS_TO_ACC)
      begin
         flag_set = before_pick;
         err_evt = before_unm;
      end
      else if (finish && !dflt_r)
      begin
         flag_set = after_pick;
         err_evt = after_unm;
      end
   end

   assign set_flags = |flag_set;
   assign wr_status = reg_wr && (reg_addr == OFS_STATUS);

   // Flags stay until software clears them; a new set wins
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         flags_r <= '0;
      else if (wr_status)
         flags_r <= (flags_r & ~reg_wdata[EXC_W-1:0]) |
                    flag_set;
      else if (set_flags)
         flags_r <= flags_r | flag_set;
   end

   // Summary bit: a set flag whose mask is clear
   assign es = |(flags_r & ~mask_r);

   // Error pin follows the summary, low while any unmasked flag
   // stands; the host picks it up at its next escape or wait
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         error_n <= 1'b1;
      else
         error_n <= ~es;
   end

   ////////////////////////////////////////////////////////////////////
   // Condition code and status word
   ////////////////////////////////////////////////////////////////////

   assign cc_upd = finish && (kind_r == OP_COMPARE ||
                   kind_r == OP_COMPARE_POP || kind_r == OP_EXAMINE);

   // Condition bits change only for compare and examine
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         cc_r <= CC_RST;
      else if (cc_upd)
         cc_r <= cc_new;
   end

   // Bits 3, 2, 0 land on zero, parity, carry of the host flags
   always_comb
   begin
      sw = '0;
      sw[EXC_W-1:0] = flags_r;
      sw[SW_SF] = 1'b0;
      sw[SW_ES] = es;
      sw[SW_CC_ZERO] = cc_r[0];
      sw[SW_CC_ONE] = cc_r[1];
      sw[SW_CC_TWO] = cc_r[2];
      sw[SW_TOP+:3] = stack_top;
      sw[SW_CC_THREE] = cc_r[3];
      sw[SW_B] = es;
   end

   // Status word goes straight to the accumulator port
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         acc_valid <= 1'b0;
         acc_data <= 16'h0000;
      end
      else
      begin
         acc_valid <= issue && (op_req.kind == OP_STATUS_TO_ACC);
         if (issue && op_req.kind == OP_STATUS_TO_ACC)
            acc_data <= sw;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register port
   ////////////////////////////////////////////////////////////////////

   assign wr_ctrl = reg_wr && (reg_addr == OFS_CTRL);
   assign wr_evt_clr = reg_wr && (reg_addr == OFS_EVT_CLR);
   assign wr_evt_en = reg_wr && (reg_addr == OFS_EVT_EN);

   // Mask register steers masked or unmasked handling
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         mask_r <= CTRL_MASK_RST;
      else if (wr_ctrl)
         mask_r <= reg_wdata[EXC_W-1:0];
   end

   // Event enables
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         evt_en_r <= EVT_RST;
      else if (wr_evt_en)
         evt_en_r <= reg_wdata[EVT_W-1:0];
   end

   // Sticky events; a set in the clearing cycle survives
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         evt_r <= EVT_RST;
      else
      begin
         evt_r <= (evt_r & ~(wr_evt_clr ? reg_wdata[EVT_W-1:0] :
                   EVT_RST)) | {cc_upd, err_evt, set_flags};
      end
   end

   // Level interrupt from enabled events
   assign irq = |(evt_r & evt_en_r);

   // Read data valid in the cycle after the strobe only
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
         reg_rdata <= '0;
      else if (reg_rd)
      begin
         case (reg_addr)
            OFS_CTRL: reg_rdata <= {26'h0, mask_r};
            OFS_STATUS: reg_rdata <= {16'h0, sw};
            OFS_EVT_STAT: reg_rdata <= {29'h0, evt_r};
            OFS_EVT_EN: reg_rdata <= {29'h0, evt_en_r};
            default: reg_rdata <= '0;
         endcase
      end
      else
         reg_rdata <= '0;
   end

endmodule

// ==== testbench/fpu_exc_properties.sv ====
// Concurrent checks on the exception commit unit's ports.
// Assumes one clock domain; bound from the testbench top file.
`timescale 1ns/1ns
module fpu_exc_props
   import fpu_exc_pkg::*;
(
   input wire logic clk_sys, // System clock
   input wire logic rstn, // Reset, active low
   input wire logic [ADDR_W-1:0] reg_addr, // Register address
   input wire logic [DATA_W-1:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic op_valid, // Issue strobe
   input wire op_req_t op_req, // Issue request
   input wire logic op_ready, // Unit idle
   input wire logic res_valid, // Result strobe
   input wire res_t res, // Result flags
   input wire logic [2:0] stack_top, // Stack top pointer
   input wire commit_t commit, // Commit decision
   input wire logic acc_valid, // Accumulator strobe
   input wire logic [15:0] acc_data, // Accumulator word
   input wire logic error_n // Error pin, active low
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////////
   logic [5:0] mask_r; // Shadow of the mask register
   op_kind_t kind_r; // Kind of the pending instruction
   logic clean_r; // Pending instruction had no operand fault
   logic take; // Issue accepted this edge
   logic early; // Picked operand fault is unmasked
   logic ovf_unm; // Picked over/underflow is unmasked
   logic clr_wr; // Flag clear or mask write this edge
   assign take = op_valid && op_ready;
   assign early = op_req.inv ? !mask_r[0] : op_req.denorm ? !mask_r[1]
      : op_req.zdiv && !mask_r[2];
   assign ovf_unm = res.ovf ? !mask_r[3] : res.unf && !mask_r[4];
   assign clr_wr = reg_wr && (reg_addr == OFS_STATUS ||
      reg_addr == OFS_CTRL);
   // Track mask writes so unmasked faults are known
   always_ff @(posedge clk_sys or negedge rstn)
      if (!rstn)
         mask_r <= CTRL_MASK_RST;
      else if (reg_wr && reg_addr == OFS_CTRL)
         mask_r <= reg_wdata[5:0];
   // Remember what the pending instruction is
   always_ff @(posedge clk_sys or negedge rstn)
      if (!rstn)
      begin
         kind_r <= OP_ARITH;
         clean_r <= 1'b0;
      end
      else if (take)
      begin
         kind_r <= op_req.kind;
         clean_r <= !(op_req.inv || op_req.zdiv || op_req.denorm);
      end
   ////////////////////////////////////////////////////////////////////
   before_abort_a:
   assert property (take && early |=> commit.valid && commit.aborted
      && !commit.wr_stack && !commit.wr_mem && !commit.pop)
      else $error("operand fault not aborted at once");
   no_early_a:
   assert property (take && !early && op_req.kind != OP_STATUS_TO_ACC
      |=> !commit.valid) else $error("commit before result");
   store_hold_a:
   assert property (res_valid && !op_ready && clean_r && ovf_unm
      && kind_r inside {OP_STORE, OP_STORE_POP}
      |=> commit.valid && !commit.wr_mem && !commit.pop)
      else $error("store committed after unmasked over/underflow");
   arith_done_a:
   assert property (res_valid && !op_ready && clean_r && kind_r == OP_ARITH
      |=> commit.valid && commit.wr_stack) else $error("arith not committed");
   acc_word_a:
   assert property (take && op_req.kind == OP_STATUS_TO_ACC |=> acc_valid
      && !commit.valid && acc_data[13:11] == $past(stack_top)
      && acc_data[SW_B] == acc_data[SW_ES]) else $error("bad status store");
   error_set_a:
   assert property (commit.valid && commit.aborted |=> !error_n)
      else $error("error pin not asserted");
   error_hold_a:
   // The pin lags the flags by one edge, so a clear excuses two edges
   assert property (!error_n && !clr_wr && !$past(clr_wr) |=> !error_n)
      else $error("error pin dropped");
   masked_quiet_a:
   assert property (error_n && mask_r == CTRL_MASK_RST |=> error_n)
      else $error("error pin with all masked");
   ready_back_a:
   assert property (commit.valid |-> op_ready) else $error("not ready");
endmodule

// ==== testbench/host_cpu_model.sv ====
// Host processor side: samples the error pin at each escape or wait.
// Assumes the testbench pulses escape_seen for one cycle per instruction.
`timescale 1ns/1ns
module host_cpu_model
(
   input wire logic clk_sys, // System clock
   input wire logic rstn, // Reset, active low
   input wire logic error_n, // Error pin from the unit
   input wire logic escape_seen, // Escape or wait decoded
   output logic [7:0] trap_vec, // Vector of the last trap
   output logic [7:0] trap_cnt // Number of traps taken
);
   // Trap only when an escape or wait finds the pin low
   always_ff @(posedge clk_sys or negedge rstn)
      if (!rstn)
      begin
         trap_vec <= 8'h00;
         trap_cnt <= 8'h00;
      end
      else if (escape_seen && !error_n)
      begin
         trap_vec <= 8'h10;
         trap_cnt <= trap_cnt + 8'h01;
      end
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the exception commit unit.
// Assumes the package is compiled first; bench drives all inputs.
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin \
   miscompares++; $display("[FAIL] %s exp %0h got %0h", n, e, g); \
   end end
module testbench
   import fpu_exc_pkg::*;
;
   logic clk_sys, rstn, reg_wr, reg_rd, op_valid, op_ready, res_valid;
   logic acc_valid, error_n, irq, escape_seen;
   logic [7:0] reg_addr, trap_vec, trap_cnt;
   logic [31:0] reg_wdata, reg_rdata;
   logic [2:0] stack_top;
   logic [15:0] acc_data;
   op_req_t op_req;
   res_t res;
   commit_t commit;
   int miscompares = 0; // Mismatches seen
   int n_checks = 0; // Comparisons made
   ////////////////////////////////////////////////////////////////////
   fpu_exc_commit i_dut (.clk_sys(clk_sys), .rstn(rstn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_valid(op_valid),
      .op_req(op_req), .op_ready(op_ready), .res_valid(res_valid),
      .res(res), .stack_top(stack_top), .commit(commit),
      .acc_valid(acc_valid), .acc_data(acc_data), .error_n(error_n),
      .irq(irq));
   host_cpu_model i_host (.clk_sys(clk_sys), .rstn(rstn),
      .error_n(error_n), .escape_seen(escape_seen), .trap_vec(trap_vec),
      .trap_cnt(trap_cnt));
   // Free running 10 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////////////////////////////////
   // One-cycle register write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      #1;
   endtask
   // One-cycle read, data checked in the following cycle
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      `CHK("rdata", e, reg_rdata)
   endtask
   // Issue one instruction with its operand checks
   task automatic iss(input op_kind_t k, input logic [2:0] f);
      @(posedge clk_sys);
      op_valid <= 1'b1;
      op_req <= {k, f};
      @(posedge clk_sys);
      op_valid <= 1'b0;
      #1;
   endtask
   // Full instruction; e is valid, stack, memory, pop, aborted
   task automatic run_op(input op_kind_t k, input logic [2:0] f,
      input res_t r, input logic [4:0] e);
      logic [4:0] got; // Commit fields as seen
      iss(k, f);
      if (!(e[0] && f != 3'h0))
      begin
         `CHK("early", 1'b0, commit.valid)
         @(posedge clk_sys);
         res_valid <= 1'b1;
         res <= r;
         @(posedge clk_sys);
         res_valid <= 1'b0;
         #1;
      end
      got = {commit.valid, commit.wr_stack, commit.wr_mem, commit.pop,
         commit.aborted};
      `CHK("commit", e, got)
   endtask
   // Status word to accumulator, condition bits compared
   task automatic acc_chk(input logic [3:0] cc);
      logic [3:0] got; // Condition bits as stored
      iss(OP_STATUS_TO_ACC, 3'h0);
      `CHK("acc_valid", 1'b1, acc_valid)
      got = {acc_data[14], acc_data[10], acc_data[9], acc_data[8]};
      `CHK("cc", cc, got)
   endtask
   ////////////////////////////////////////////////////////////////////
   // Values after reset, unmapped read
   task automatic t_reset;
      rd(OFS_CTRL, 32'h3F);
      rd(OFS_STATUS, 32'h0);
      rd(8'h14, 32'h0);
      `CHK("error_n", 1'b1, error_n)
      `CHK("irq", 1'b0, irq)
   endtask
   // Unmasked operand faults, trap, interrupt, clearing
   task automatic t_before;
      wr(OFS_CTRL, 32'h0);
      stack_top <= 3'h5;
      run_op(OP_ARITH, 3'h6, 9'h0, 5'h11);
      `CHK("trap", 8'h0, trap_cnt)
      repeat (4) @(posedge clk_sys);
      rd(OFS_STATUS, 32'hA881);
      @(posedge clk_sys);
      escape_seen <= 1'b1;
      @(posedge clk_sys);
      escape_seen <= 1'b0;
      #1;
      `CHK("trap", 8'h1, trap_cnt)
      `CHK("vector", 8'h10, trap_vec)
      wr(OFS_EVT_EN, 32'h2);
      `CHK("irq", 1'b1, irq)
      rd(OFS_EVT_STAT, 32'h3);
      `CHK("error_n", 1'b0, error_n)
      wr(OFS_STATUS, 32'h3F);
      @(posedge clk_sys);
      #1;
      `CHK("error_n", 1'b1, error_n)
      rd(OFS_STATUS, 32'h2800);
      wr(OFS_EVT_STAT, 32'h7);
      wr(OFS_EVT_CLR, 32'h7);
      `CHK("irq", 1'b0, irq)
      rd(OFS_EVT_STAT, 32'h0);
   endtask
   // Result-time faults on arithmetic and stores
   task automatic t_after;
      run_op(OP_ARITH, 3'h0, 9'h040, 5'h18);
      rd(OFS_STATUS, 32'hA8A0);
      run_op(OP_STORE, 3'h0, 9'h100, 5'h11);
      run_op(OP_STORE_POP, 3'h0, 9'h080, 5'h11);
      wr(OFS_STATUS, 32'h3F);
      wr(OFS_CTRL, 32'h3F);
      run_op(OP_STORE_POP, 3'h0, 9'h100, 5'h16);
   endtask
   // Masked operand fault takes the default and stays quiet
   task automatic t_masked;
      run_op(OP_ARITH, 3'h2, 9'h0, 5'h18);
      `CHK("default", 1'b1, commit.use_default)
      repeat (3) @(posedge clk_sys);
      #1;
      `CHK("error_n", 1'b1, error_n)
      rd(OFS_STATUS, 32'h280C);
   endtask
   // All four compare orderings through the accumulator
   task automatic t_cc;
      logic [3:0] ccx [4];
      ccx = '{4'h0, 4'h1, 4'h8, 4'hD};
      for (int i = 0; i < 4; i++)
      begin
         stack_top <= 3'(i);
         run_op(OP_COMPARE_POP, 3'h0, {3'h0, 2'(i), 4'h0}, 5'h12);
         acc_chk(ccx[i]);
      end
   endtask
   // Every examine class, sign alternating
   task automatic t_exam;
      logic s;
      for (int c = 0; c < 7; c++)
      begin
         s = ~c[0];
         run_op(OP_EXAMINE, 3'h0, {5'h0, 3'(c), s}, 5'h10);
         acc_chk({c[2], c[1], s, c[0]});
      end
   endtask
   ////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Cut a hang short after far more than the tests need
   initial
   begin
      #(5000 * 100);
      miscompares++;
      tally_and_finish;
   end
   // Main sequence
   initial
   begin
      rstn = 1'b0;
      {reg_wr, reg_rd, op_valid, res_valid, escape_seen} = 5'h0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      op_req = '0;
      res = '0;
      stack_top = 3'h0;
      repeat (2) @(posedge clk_sys);
      rstn <= 1'b1;
      t_reset;
      t_before;
      t_after;
      t_masked;
      t_cc;
      t_exam;
      tally_and_finish;
   end
endmodule
bind fpu_exc_commit fpu_exc_props i_props (.clk_sys(clk_sys),
   .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .op_valid(op_valid), .op_req(op_req),
   .op_ready(op_ready), .res_valid(res_valid), .res(res),
   .stack_top(stack_top), .commit(commit), .acc_valid(acc_valid),
   .acc_data(acc_data), .error_n(error_n));
